// file: cti_pkg.sv
package cti_pkg;
    // register map, reached through the device's own register port
    localparam logic [7:0] CTI_PORT_SEL_ADDR  = 8'h32;
    localparam logic [7:0] CTI_LIVE_STS_ADDR  = 8'h35;
    localparam logic [7:0] CTI_IRQ_EN_ADDR    = 8'h36;
    localparam logic [7:0] CTI_IRQ_STS_ADDR   = 8'h37;
    localparam logic [7:0] CTI_IRQ_EN_RESET   = 8'h00;
    localparam logic [7:0] CTI_IRQ_STS_RESET  = 8'h00;
    localparam logic [4:0] CTI_IRQ_FIELD_MASK = 5'h1f;
    // field positions shared by enable and status registers
    localparam int CTI_BIT_PASS     = 0;
    localparam int CTI_BIT_PASS_ERR = 1;
    localparam int CTI_BIT_SYNCED   = 2;
    localparam int CTI_BIT_SYNC_ERR = 3;
    localparam int CTI_BIT_RX_SUM   = 4;
    localparam int CTI_NUM_SRC      = 5;
    // live status register fields
    localparam int CTI_LIVE_PASS    = 0;
    localparam int CTI_LIVE_SYNC    = 1;
    localparam int CTI_LIVE_PORTNUM = 4;
endpackage : cti_pkg

// file: cti_tx_status.sv
// live pass and synchronized levels for one transmit port
module cti_tx_status
    import cti_pkg::*;
#(
    parameter int NUM_RX = 4
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    input  wire logic [NUM_RX-1:0] rx_enabled_in,
    input  wire logic [NUM_RX-1:0] rx_valid_in,
    input  wire logic              all_ports_mode_in,
    input  wire logic              sync_enable_in,
    input  wire logic              sync_achieved_in,
    input  wire logic              async_mode_in,
    input  wire logic              tx_error_in,
    output logic                   pass_out,
    output logic                   synced_out
);
    logic pass_reg;
    logic pass_next;
    logic synced_reg;
    logic synced_next;
    logic any_ok;
    logic all_ok;

    // next-state for both live levels
    always_comb begin
        any_ok = |(rx_enabled_in & rx_valid_in);
        all_ok = any_ok && ((rx_enabled_in & ~rx_valid_in) == '0);
        pass_next = all_ports_mode_in ? all_ok : any_ok;
        if (async_mode_in && tx_error_in) begin
            pass_next = 1'b0;
        end
        synced_next = sync_enable_in && sync_achieved_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pass_reg   <= 1'b0;
            synced_reg <= 1'b0;
        end else if (clk_en_in) begin
            pass_reg   <= pass_next;
            synced_reg <= synced_next;
        end
    end

    assign pass_out   = pass_reg;
    assign synced_out = synced_reg;

    // a_sync_off_low
    a_sync_off_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && !sync_enable_in) |=> !synced_reg)
        else $error("synced high while sync disabled");

    // a_pass_err_drop
    a_pass_err_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && async_mode_in && tx_error_in) |=> !pass_reg)
        else $error("pass not cleared on transmit error");

    // a_pass_any_mode
    a_pass_any_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && !all_ports_mode_in && !(async_mode_in && tx_error_in)
         && |(rx_enabled_in & rx_valid_in)) |=> pass_reg)
        else $error("pass missing with one valid port");

    // a_pass_all_mode
    a_pass_all_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && all_ports_mode_in && |(rx_enabled_in & ~rx_valid_in)) |=> !pass_reg)
        else $error("pass high with an enabled port not valid");
endmodule : cti_tx_status

// file: cti_irq.sv
// Overview of operation
// - enable bit 4 gates the receive-port summary interrupt
// - enable bit 3 gates the synchronization error interrupt
// - enable bit 2 gates the synchronized-assert interrupt
// - enable bit 1 gates the pass-lost interrupt
// - enable bit 0 gates the pass-assert interrupt
// - status bit 4 sets when a forwarded receive port interrupts
// - bit 4 clears only on reading a forwarded port's receive status
// - status bit 3 latches sync errors, clears on read
// - status bit 2 latches synced rising edge, clears on read
// - status bit 1 latches pass loss on forwarded ports, clears on read
// - status bit 0 latches pass rising edge, clears on read
// - both registers are per transmit port, chosen by port select
// - enable resets to zero; bits 7:5 read zero
// - status resets to zero
// - pass needs one enabled valid port, or all in all-ports mode
// - synced is low while synchronization is disabled
// - asynchronous forwarding clears pass on a transmission error
module cti_irq
    import cti_pkg::*;
#(
    parameter int NUM_TX = 2,
    parameter int NUM_RX = 4
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    // register port: single-cycle strobes, read data registered
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic [7:0]        reg_wdata_in,
    output logic      [7:0]        reg_rdata_out,
    // live inputs: receive-port vectors and all-ports mode shared, forward map, sync and error per transmit port
    input  wire logic [NUM_RX-1:0] rx_enabled_in,
    input  wire logic [NUM_RX-1:0] rx_valid_in,
    input  wire logic [NUM_RX-1:0] rx_fwd_map_in [NUM_TX],
    input  wire logic [NUM_RX-1:0] rx_pass_in,
    input  wire logic [NUM_RX-1:0] rx_irq_in,
    input  wire logic [NUM_RX-1:0] rx_isr_read_in,
    input  wire logic              all_ports_mode_in,
    input  wire logic [NUM_TX-1:0] sync_enable_in,
    input  wire logic [NUM_TX-1:0] sync_achieved_in,
    input  wire logic [NUM_TX-1:0] sync_error_in,
    input  wire logic [NUM_TX-1:0] async_mode_in,
    input  wire logic [NUM_TX-1:0] tx_error_in,
    output logic      [NUM_TX-1:0] irq_out
);
    localparam int SELW = (NUM_TX > 1) ? $clog2(NUM_TX) : 1;

    logic [SELW-1:0]        sel_reg;
    logic [SELW-1:0]        sel_next;
    logic [4:0]             en_reg    [NUM_TX];
    logic [4:0]             en_next   [NUM_TX];
    logic [4:0]             flag_reg  [NUM_TX];
    logic [4:0]             flag_next [NUM_TX];
    logic [NUM_TX-1:0]      pass_live;
    logic [NUM_TX-1:0]      sync_live;
    logic [NUM_TX-1:0]      pass_prev_reg;
    logic [NUM_TX-1:0]      sync_prev_reg;
    logic [NUM_RX-1:0]      rxp_prev_reg;
    logic [7:0]             rdata_next;
    logic [NUM_TX-1:0]      irq_next;

    // zero-extend a five-bit field into a byte
    function automatic logic [7:0] cti_byte(input logic [4:0] f);
        cti_byte = {3'h0, f};
    endfunction : cti_byte

    // live status generators, one per transmit port
    for (genvar t = 0; t < NUM_TX; t++) begin : g_live
        cti_tx_status #(.NUM_RX(NUM_RX)) u_sts (
            .clk_in            (clk_in),
            .rst_n_in          (rst_n_in),
            .clk_en_in         (clk_en_in),
            .rx_enabled_in     (rx_enabled_in & rx_fwd_map_in[t]),
            .rx_valid_in       (rx_valid_in),
            .all_ports_mode_in (all_ports_mode_in),
            .sync_enable_in    (sync_enable_in[t]),
            .sync_achieved_in  (sync_achieved_in[t]),
            .async_mode_in     (async_mode_in[t]),
            .tx_error_in       (tx_error_in[t]),
            .pass_out          (pass_live[t]),
            .synced_out        (sync_live[t])
        );
    end

    // register writes, sticky flags and interrupt outputs
    always_comb begin
        logic [4:0] ev;
        logic       rd_sts;
        ev         = '0;
        rd_sts     = 1'b0;
        sel_next   = sel_reg;
        rdata_next = 8'h00;
        if (reg_wr_in && reg_addr_in == CTI_PORT_SEL_ADDR) begin
            sel_next = reg_wdata_in[SELW-1:0];
        end
        for (int t = 0; t < NUM_TX; t++) begin
            en_next[t]   = en_reg[t];
            flag_next[t] = flag_reg[t];
            rd_sts = reg_rd_in && reg_addr_in == CTI_IRQ_STS_ADDR && sel_reg == SELW'(t);
            if (reg_wr_in && reg_addr_in == CTI_IRQ_EN_ADDR && sel_reg == SELW'(t)) begin
                en_next[t] = reg_wdata_in[4:0] & CTI_IRQ_FIELD_MASK;
            end
            ev[CTI_BIT_PASS]     = pass_live[t] && !pass_prev_reg[t];
            ev[CTI_BIT_PASS_ERR] = |(rxp_prev_reg & ~rx_pass_in & rx_fwd_map_in[t]);
            ev[CTI_BIT_SYNCED]   = sync_live[t] && !sync_prev_reg[t];
            ev[CTI_BIT_SYNC_ERR] = sync_error_in[t];
            ev[CTI_BIT_RX_SUM]   = |(rx_irq_in & rx_fwd_map_in[t]);
            if (rd_sts) begin
                flag_next[t][3:0] = 4'h0;
            end
            // summary clears on receive status read
            if (|(rx_isr_read_in & rx_fwd_map_in[t])) begin
                flag_next[t][CTI_BIT_RX_SUM] = 1'b0;
            end
            flag_next[t] = flag_next[t] | ev;
            irq_next[t] = |(flag_reg[t] & en_reg[t]);
        end
        unique case (reg_addr_in)
            CTI_PORT_SEL_ADDR: rdata_next = 8'(sel_reg);
            CTI_LIVE_STS_ADDR: begin
                rdata_next[CTI_LIVE_PASS]    = pass_live[sel_reg];
                rdata_next[CTI_LIVE_SYNC]    = sync_live[sel_reg];
                rdata_next[CTI_LIVE_PORTNUM] = sel_reg[0];
            end
            CTI_IRQ_EN_ADDR:   rdata_next = cti_byte(en_reg[sel_reg]);
            CTI_IRQ_STS_ADDR:  rdata_next = cti_byte(flag_reg[sel_reg]);
            default:           rdata_next = 8'h00;
        endcase
        if (!reg_rd_in) begin
            rdata_next = reg_rdata_out;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_reg       <= '0;
            pass_prev_reg <= '0;
            sync_prev_reg <= '0;
            rxp_prev_reg  <= '0;
            reg_rdata_out <= 8'h00;
            irq_out       <= '0;
            for (int t = 0; t < NUM_TX; t++) begin
                en_reg[t]   <= CTI_IRQ_EN_RESET[4:0];
                flag_reg[t] <= CTI_IRQ_STS_RESET[4:0];
            end
        end else if (clk_en_in) begin
            sel_reg       <= sel_next;
            pass_prev_reg <= pass_live;
            sync_prev_reg <= sync_live;
            rxp_prev_reg  <= rx_pass_in;
            reg_rdata_out <= rdata_next;
            irq_out       <= irq_next;
            for (int t = 0; t < NUM_TX; t++) begin
                en_reg[t]   <= en_next[t];
                flag_reg[t] <= flag_next[t];
            end
        end
    end

    // a_irq_follows_flags
    a_irq_follows_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        clk_en_in |=> irq_out[0] == |($past(flag_reg[0]) & $past(en_reg[0])))
        else $error("interrupt does not follow enabled flags");
    // a_sync_err_latch
    a_sync_err_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && sync_error_in[0]) |=> flag_reg[0][CTI_BIT_SYNC_ERR])
        else $error("sync error not latched");
    // a_read_clears
    a_read_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && reg_rd_in && reg_addr_in == CTI_IRQ_STS_ADDR && sel_reg == '0
         && !(pass_live[0] && !pass_prev_reg[0])) |=> !flag_reg[0][CTI_BIT_PASS])
        else $error("pass flag not cleared by read");
    // a_sum_survives_read
    a_sum_survives_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && flag_reg[0][CTI_BIT_RX_SUM] && !(|(rx_isr_read_in & rx_fwd_map_in[0])))
        |=> flag_reg[0][CTI_BIT_RX_SUM])
        else $error("summary flag lost without receive status read");
    // a_rx_sum_set
    a_rx_sum_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && |(rx_irq_in & rx_fwd_map_in[0])) |=> flag_reg[0][CTI_BIT_RX_SUM])
        else $error("summary flag not set");
    // a_synced_edge
    a_synced_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && sync_live[0] && !sync_prev_reg[0]) |=> flag_reg[0][CTI_BIT_SYNCED])
        else $error("synced edge not latched");
    // a_pass_loss
    a_pass_loss: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && |(rxp_prev_reg & ~rx_pass_in & rx_fwd_map_in[0]))
        |=> flag_reg[0][CTI_BIT_PASS_ERR])
        else $error("pass loss not latched");
    // a_en_write_sel
    a_en_write_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in && reg_wr_in && reg_addr_in == CTI_IRQ_EN_ADDR && sel_reg == '0)
        |=> en_reg[0] == $past(reg_wdata_in[4:0]))
        else $error("enable write lost");
    // a_reset_quiet
    a_reset_quiet: assert property (@(posedge clk_in) $rose(rst_n_in) |-> irq_out == '0)
        else $error("interrupt active out of reset");

    c_irq_raised:  cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_out[0]));
    c_read_clear:  cover property (@(posedge clk_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == CTI_IRQ_STS_ADDR && flag_reg[0] != '0);
    c_port1_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        reg_wr_in && reg_addr_in == CTI_IRQ_EN_ADDR && sel_reg == SELW'(1));
endmodule : cti_irq

// file: cti_host_model.sv
// host side of the register port: one-cycle strobes, bytes only
module cti_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] reg_rdata_in,
    output logic      [7:0] reg_addr_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic      [7:0] reg_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 8'h00;
    end

    // released address and data flip, so a stale value is never mistaken for a live one
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        reg_addr_out = a;
        reg_wr_out = w;
        reg_rd_out = !w;
        reg_wdata_out = d;
        @(posedge clk_in);
        #1;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask : access

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        access(a, 1'b1, d);
    endtask : write_reg

    // read data is taken just after the taking edge, where it already stands until the next read
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        access(a, 1'b0, 8'h00);
        d = reg_rdata_in;
    endtask : read_reg
endmodule : cti_host_model

// file: testbench.sv
module testbench
    import cti_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [7:0] addr, wdata, rdata, rv;
    logic       wr, rd, all_mode;
    logic       clk_en = 1'b1;
    logic [3:0] rx_en, rx_vld, rx_pass, rx_irq, rx_clr;
    logic [3:0] fwd_map [2];
    logic [1:0] sync_en, sync_ach, sync_err, async_m, tx_err, irq;
    int         miscompares = 0;
    int         total_checks = 0;

    // 25 mhz clock
    always #20 clk_in = ~clk_in;

    cti_irq #(.NUM_TX(2), .NUM_RX(4)) i_cti_irq (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .rx_enabled_in(rx_en), .rx_valid_in(rx_vld), .rx_fwd_map_in(fwd_map),
        .rx_pass_in(rx_pass), .rx_irq_in(rx_irq), .rx_isr_read_in(rx_clr),
        .all_ports_mode_in(all_mode), .sync_enable_in(sync_en),
        .sync_achieved_in(sync_ach), .sync_error_in(sync_err),
        .async_mode_in(async_m), .tx_error_in(tx_err), .irq_out(irq));

    cti_host_model i_cti_host_model (
        .clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_cti_host_model.read_reg(a, rv);
        chk(rv, exp);
    endtask : rd_chk

    // one clean event of source b on tx port 0, level restored afterwards
    task automatic fire(input int b);
        case (b)
            0: rx_vld[0] = 1'b1;
            1: rx_pass[0] = 1'b0;
            2: sync_ach[0] = 1'b1;
            3: sync_err[0] = 1'b1;
            default: rx_irq[0] = 1'b1;
        endcase
        cyc(1);
        sync_err[0] = 1'b0;
        rx_irq[0] = 1'b0;
        cyc(3);
        rx_vld[0] = 1'b0;
        rx_pass[0] = 1'b1;
        sync_ach[0] = 1'b0;
        cyc(4);
    endtask : fire

    // summary flag survives the status read and needs the receive-side read
    task automatic clear_chk(input int b);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h01 << b);
        if (b == CTI_BIT_RX_SUM) begin
            rd_chk(CTI_IRQ_STS_ADDR, 8'h10);
            rx_clr[0] = 1'b1;
            cyc(1);
            rx_clr[0] = 1'b0;
            cyc(2);
        end
        rd_chk(CTI_IRQ_STS_ADDR, 8'h00);
        cyc(3);
        chk({7'h00, irq[0]}, 8'h00);
    endtask : clear_chk

    task automatic stop_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // watchdog, far beyond the roughly 270 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        $display("ERROR t=%0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        all_mode = 1'b0;
        rx_en = 4'h1;
        rx_vld = 4'h0;
        rx_pass = 4'hf;
        rx_irq = 4'h0;
        rx_clr = 4'h0;
        fwd_map[0] = 4'h3;
        fwd_map[1] = 4'h2;
        sync_en = 2'h3;
        sync_ach = 2'h0;
        sync_err = 2'h0;
        async_m = 2'h0;
        tx_err = 2'h0;
        cyc(5);
        rst_n_in = 1'b1;
        rd_chk(CTI_IRQ_EN_ADDR, 8'h00);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h00);
        i_cti_host_model.write_reg(CTI_IRQ_EN_ADDR, 8'hff);
        rd_chk(CTI_IRQ_EN_ADDR, 8'h1f);
        // each source with every other enable set, then with its own
        for (int b = 0; b < CTI_NUM_SRC; b++) begin
            i_cti_host_model.write_reg(CTI_IRQ_EN_ADDR, 8'h1f ^ (8'h01 << b));
            fire(b);
            chk({7'h00, irq[0]}, 8'h00);
            clear_chk(b);
            i_cti_host_model.write_reg(CTI_IRQ_EN_ADDR, 8'h01 << b);
            fire(b);
            chk({7'h00, irq[0]}, 8'h01);
            clear_chk(b);
        end
        // event in the very cycle of the clearing read
        sync_err[0] = 1'b1;
        fork
            i_cti_host_model.read_reg(CTI_IRQ_STS_ADDR, rv);
            begin
                cyc(2);
                sync_err[0] = 1'b0;
            end
        join
        chk(rv, 8'h08);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h08);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h00);
        // a low clock enable freezes the flags, so this error pulse is never latched
        clk_en = 1'b0;
        sync_err[0] = 1'b1;
        cyc(2);
        sync_err[0] = 1'b0;
        clk_en = 1'b1;
        cyc(1);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h00);
        // second tx port copy
        i_cti_host_model.write_reg(CTI_PORT_SEL_ADDR, 8'h01);
        rd_chk(CTI_PORT_SEL_ADDR, 8'h01);
        rd_chk(CTI_LIVE_STS_ADDR, 8'h10);
        rd_chk(CTI_IRQ_EN_ADDR, 8'h00);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h00);
        i_cti_host_model.write_reg(CTI_IRQ_EN_ADDR, 8'h08);
        sync_err[1] = 1'b1;
        cyc(1);
        sync_err[1] = 1'b0;
        cyc(3);
        chk({6'h00, irq}, 8'h02);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h08);
        i_cti_host_model.write_reg(CTI_PORT_SEL_ADDR, 8'h00);
        // live pass and synced levels
        all_mode = 1'b1;
        rx_en = 4'h3;
        rx_vld = 4'h1;
        cyc(4);
        rd_chk(CTI_LIVE_STS_ADDR, 8'h00);
        rx_vld = 4'h3;
        cyc(4);
        rd_chk(CTI_LIVE_STS_ADDR, 8'h01);
        async_m[0] = 1'b1;
        tx_err[0] = 1'b1;
        cyc(4);
        rd_chk(CTI_LIVE_STS_ADDR, 8'h00);
        async_m[0] = 1'b0;
        tx_err[0] = 1'b0;
        sync_en[0] = 1'b0;
        sync_ach[0] = 1'b1;
        cyc(4);
        rd_chk(CTI_LIVE_STS_ADDR, 8'h01);
        sync_en[0] = 1'b1;
        cyc(4);
        rd_chk(CTI_LIVE_STS_ADDR, 8'h03);
        // pass and synced flags still pend, so full enables raise the request
        i_cti_host_model.write_reg(CTI_IRQ_EN_ADDR, 8'h1f);
        rx_vld = 4'h0;
        sync_ach[0] = 1'b0;
        cyc(3);
        chk({7'h00, irq[0]}, 8'h01);
        // mid-run reset drops the request at once and empties both registers
        rst_n_in = 1'b0;
        cyc(2);
        chk({7'h00, irq[0]}, 8'h00);
        rst_n_in = 1'b1;
        rd_chk(CTI_IRQ_EN_ADDR, 8'h00);
        rd_chk(CTI_IRQ_STS_ADDR, 8'h00);
        stop_test();
    end
endmodule : testbench
